// >>> thc_pkg.sv
// Package with timing constants and state types for the two-hand control monitor
package thc_pkg;
   localparam int unsigned CLOCK_HZ            = 250_000_000;
   localparam int unsigned SIMUL_WINDOW_MS     = 500;
   localparam int unsigned FB_CLOSE_MS         = 150;
   // Short filter keeps the response fast; very bouncy buttons need a longer value
   localparam int unsigned DEBOUNCE_US         = 4;
   localparam int unsigned INIT_US             = 4;
   localparam int unsigned OFF_TEST_PERIOD_MS  = 100;
   localparam int unsigned OFF_TEST_PULSE_US   = 1;
   localparam int unsigned FLASH_HALF_MS       = 250;
   localparam int unsigned FLASH_PAUSE_MS      = 1000;
   // Longest time and least time both round down
   localparam int unsigned SIMUL_CYCLES     = CLOCK_HZ / 1000 * SIMUL_WINDOW_MS;
   localparam int unsigned FB_CLOSE_CYCLES  = CLOCK_HZ / 1000 * FB_CLOSE_MS;
   localparam int unsigned DEBOUNCE_CYCLES  = CLOCK_HZ / 1_000_000 * DEBOUNCE_US;
   localparam int unsigned INIT_CYCLES      = CLOCK_HZ / 1_000_000 * INIT_US;
   localparam int unsigned OFF_PERIOD_CYCLES = CLOCK_HZ / 1000 * OFF_TEST_PERIOD_MS;
   localparam int unsigned OFF_PULSE_CYCLES = CLOCK_HZ / 1_000_000 * OFF_TEST_PULSE_US;
   localparam int unsigned FLASH_HALF_CYCLES = CLOCK_HZ / 1000 * FLASH_HALF_MS;
   localparam int unsigned FLASH_PAUSE_CYCLES = CLOCK_HZ / 1000 * FLASH_PAUSE_MS;
   localparam logic [3:0]  FLASH_CODE_MAJOR = 4'h1;
   localparam logic [3:0]  FLASH_CODE_MINOR = 4'h8;
   localparam int unsigned TIMER_W          = 32;

   typedef enum logic [2:0] {
      ST_INIT,
      ST_IDLE,
      ST_WINDOW,
      ST_ACTIVE,
      ST_WAIT_RELEASE,
      ST_FB_ERROR,
      ST_FB_LOCKOUT
   } thc_state_t;
endpackage : thc_pkg

// >>> input_filter.sv
// Two-flop synchroniser followed by a debounce filter for one pin
`timescale 1ns/1ps
`default_nettype none
module input_filter
   import thc_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = 250_000
) (
   input  wire logic i_clock,
   input  wire logic i_resetn,
   input  wire logic i_pin,
   output logic      o_level
);
   logic                 meta_q;
   logic                 sync_q;
   logic                 level_q, level_d;
   logic [TIMER_W-1:0]   count_q, count_d;

   always_comb begin
      level_d = level_q;
      count_d = '0;
      if (sync_q != level_q) begin
         count_d = count_q + 1'b1;
         if (count_q >= TIMER_W'(STABLE_CYCLES - 1)) begin
            level_d = sync_q;
            count_d = '0;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         level_q <= 1'b0;
         count_q <= '0;
      end else begin
         meta_q  <= i_pin;
         sync_q  <= meta_q;
         level_q <= level_d;
         count_q <= count_d;
      end
   end

   assign o_level = level_q;
endmodule : input_filter
`default_nettype wire

// >>> two_hand_control_logic.sv
// Two-hand control monitor: simultaneity, feedback checks, off-test and LEDs
`timescale 1ns/1ps
`default_nettype none
module two_hand_control_logic
   import thc_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_resetn,
   input  wire logic i_btn_a_no,
   input  wire logic i_btn_a_nc,
   input  wire logic i_btn_b_no,
   input  wire logic i_btn_b_nc,
   input  wire logic i_fb_in_a,
   input  wire logic i_fb_in_b,
   input  wire logic i_or_link_in,
   input  wire logic i_and_link_in,
   input  wire logic i_and_mode,
   input  wire logic i_safety_reset,
   output logic      o_safety_out_a,
   output logic      o_safety_out_b,
   output logic      o_aux_out,
   output logic      o_power_led,
   output logic      o_chan_a_led,
   output logic      o_chan_b_led,
   output logic      o_ready,
   output logic      o_error
);
   // -----------------------------------------------------------------
   // Input conditioning
   // -----------------------------------------------------------------
   logic a_no, a_nc, b_no, b_nc, fb_a, fb_b, or_l, and_l, and_m, rst_req;
   logic [9:0] raw_pins;
   logic [9:0] filt;

   assign raw_pins = {i_btn_a_no, i_btn_a_nc, i_btn_b_no, i_btn_b_nc, i_fb_in_a,
                      i_fb_in_b, i_or_link_in, i_and_link_in, i_and_mode, i_safety_reset};

   for (genvar g = 0; g < 10; g++) begin : g_filt
      input_filter #(
         .STABLE_CYCLES (DEBOUNCE_CYCLES)
      ) u_filt (
         .i_clock  (i_clock),
         .i_resetn (i_resetn),
         .i_pin    (raw_pins[g]),
         .o_level  (filt[g])
      );
   end

   assign {a_no, a_nc, b_no, b_nc, fb_a, fb_b, or_l, and_l, and_m, rst_req} = filt;

   // A button counts only when N/O closed and N/C open; mixed states count as neither pressed nor released
   logic press_a, press_b, rel_a, rel_b;
   assign press_a = a_no & ~a_nc;
   assign press_b = b_no & ~b_nc;
   assign rel_a   = ~a_no & a_nc;
   assign rel_b   = ~b_no & b_nc;

   logic fb_closed;
   assign fb_closed = fb_a & fb_b;

   // Cascade enable: AND link or OR link must hold when the mode strap selects AND mode
   logic and_mode_q, and_mode_d;
   logic link_ok;
   assign link_ok = (and_mode_q ? and_l : 1'b1) | or_l;

   // -----------------------------------------------------------------
   // Main sequencer
   // -----------------------------------------------------------------
   thc_state_t          state_q, state_d;
   logic [TIMER_W-1:0]  timer_q, timer_d;
   logic                power_q, power_d;
   logic                outs_on;

   always_comb begin
      state_d    = state_q;
      timer_d    = timer_q + 1'b1;
      and_mode_d = and_mode_q;
      power_d    = power_q;
      unique case (state_q)
         ST_INIT: begin
            // Mode strap is caught after the filters have settled
            if (timer_q >= TIMER_W'(INIT_CYCLES + 2 * DEBOUNCE_CYCLES)) begin
               and_mode_d = and_m;
               power_d    = 1'b1;
               state_d    = ST_WAIT_RELEASE;
               timer_d    = '0;
            end
         end
         ST_IDLE: begin
            // Feedback is checked at the first press, before anything can switch
            timer_d = '0;
            if (press_a | press_b) begin
               if (!fb_closed) begin
                  state_d = ST_FB_ERROR;
               end else begin
                  state_d = ST_WINDOW;
               end
            end
         end
         ST_WINDOW: begin
            // Letting go before the second press restarts the window from idle
            if (!(press_a | press_b)) begin
               state_d = ST_IDLE;
            end else if (timer_q >= TIMER_W'(SIMUL_CYCLES)) begin
               state_d = ST_WAIT_RELEASE;
            end else if (press_a & press_b) begin
               if (!fb_closed) begin
                  state_d = ST_FB_ERROR;
               end else if (link_ok) begin
                  state_d = ST_ACTIVE;
                  timer_d = '0;
               end
            end
         end
         ST_ACTIVE: begin
            if (!(press_a & press_b) || !link_ok) begin
               state_d = ST_WAIT_RELEASE;
               timer_d = '0;
            end
         end
         ST_WAIT_RELEASE: begin
            // Feedback must be back within the limit after any switch-off
            if (!fb_closed && timer_q >= TIMER_W'(FB_CLOSE_CYCLES)) begin
               state_d = ST_FB_LOCKOUT;
            end else if (fb_closed && rel_a && rel_b) begin
               state_d = ST_IDLE;
            end
            // Timer saturates so a long wait cannot wrap back under the limit
            if (timer_q >= TIMER_W'(FB_CLOSE_CYCLES)) begin
               timer_d = timer_q;
            end
         end
         ST_FB_ERROR: begin
            // A held button cannot re-arm through the reset request
            timer_d = '0;
            if (fb_closed && rst_req && rel_a && rel_b) begin
               state_d = ST_IDLE;
            end
         end
         ST_FB_LOCKOUT: begin
            // Only a power-on reset leaves this state
            timer_d = '0;
         end
         default: begin
            state_d = ST_INIT;
            timer_d = '0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q    <= ST_INIT;
         timer_q    <= '0;
         and_mode_q <= 1'b0;
         power_q    <= 1'b0;
      end else begin
         state_q    <= state_d;
         timer_q    <= timer_d;
         and_mode_q <= and_mode_d;
         power_q    <= power_d;
      end
   end

   assign outs_on = (state_q == ST_ACTIVE);

   // -----------------------------------------------------------------
   // Off-test pulse generator
   // -----------------------------------------------------------------
   // Short low pulse; too short for contactors to drop, long enough to check
   logic [TIMER_W-1:0] otest_q, otest_d;
   logic               otest_low;

   always_comb begin
      otest_d = otest_q + 1'b1;
      if (otest_q >= TIMER_W'(OFF_PERIOD_CYCLES + OFF_PULSE_CYCLES - 1)) begin
         otest_d = '0;
      end
   end
   assign otest_low = (otest_q >= TIMER_W'(OFF_PERIOD_CYCLES));

   // -----------------------------------------------------------------
   // Flash patterns for error display
   // -----------------------------------------------------------------
   // Code 1,8: one flash, pause, eight flashes, long pause
   logic [TIMER_W-1:0] flash_t_q, flash_t_d;
   logic               phase_q, phase_d;
   logic [4:0]         blink_q, blink_d;

   always_comb begin
      flash_t_d = flash_t_q + 1'b1;
      phase_d   = phase_q;
      blink_d   = blink_q;
      if (flash_t_q >= TIMER_W'(FLASH_HALF_CYCLES - 1)) begin
         flash_t_d = '0;
         phase_d   = ~phase_q;
         if (phase_q) begin
            blink_d = (blink_q >= 5'(FLASH_CODE_MAJOR + FLASH_CODE_MINOR + 5)) ?
                      5'h00 : blink_q + 1'b1;
         end
      end
   end

   // Blink slots: 0 major flash, 1-2 pause, 3-10 minor flashes, rest pause
   logic code_on;
   always_comb begin
      code_on = 1'b0;
      if (phase_q) begin
         if (blink_q < 5'(FLASH_CODE_MAJOR)) begin
            code_on = 1'b1;
         end else if (blink_q >= 5'(FLASH_CODE_MAJOR + 2) &&
                      blink_q <  5'(FLASH_CODE_MAJOR + 2 + FLASH_CODE_MINOR)) begin
            code_on = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         otest_q   <= '0;
         flash_t_q <= '0;
         phase_q   <= 1'b0;
         blink_q   <= 5'h00;
      end else begin
         otest_q   <= otest_d;
         flash_t_q <= flash_t_d;
         phase_q   <= phase_d;
         blink_q   <= blink_d;
      end
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   logic out_a_q, out_b_q, aux_q, led_a_q, led_b_q;
   logic out_d;
   logic led_a_d, led_b_d;
   logic err_q, err_d;

   // Aux and LEDs ignore the off-test so the indicators stay steady
   // Error flag is registered so it lines up with the LED and output flops
   always_comb begin
      out_d   = outs_on & ~otest_low;
      led_a_d = outs_on;
      led_b_d = outs_on;
      err_d   = (state_q == ST_FB_ERROR) | (state_q == ST_FB_LOCKOUT);
      if (state_q == ST_FB_ERROR) begin
         led_a_d = phase_q;
         led_b_d = ~phase_q;
      end else if (state_q == ST_FB_LOCKOUT) begin
         led_a_d = code_on;
         led_b_d = code_on;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         aux_q   <= 1'b0;
         led_a_q <= 1'b0;
         led_b_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         out_a_q <= out_d;
         out_b_q <= out_d;
         aux_q   <= outs_on;
         led_a_q <= led_a_d;
         led_b_q <= led_b_d;
         err_q   <= err_d;
      end
   end

   assign o_safety_out_a = out_a_q;
   assign o_safety_out_b = out_b_q;
   assign o_aux_out      = aux_q;
   assign o_power_led    = power_q;
   assign o_chan_a_led   = led_a_q;
   assign o_chan_b_led   = led_b_q;
   assign o_ready        = power_q & fb_closed;
   assign o_error        = err_q;
endmodule : two_hand_control_logic
`default_nettype wire

// >>> thc_far_side.sv
// Far-side model: two pushbuttons with paired contacts and two feedback contactors
`timescale 1ns/1ps
`default_nettype none
module thc_far_side (
   input  wire logic i_clock,
   input  wire logic i_press_a,
   input  wire logic i_press_b,
   input  wire logic i_open_a,
   input  wire logic i_open_b,
   input  wire logic i_safety_out_a,
   input  wire logic i_safety_out_b,
   output logic      o_btn_a_no,
   output logic      o_btn_a_nc,
   output logic      o_btn_b_no,
   output logic      o_btn_b_nc,
   output logic      o_fb_in_a,
   output logic      o_fb_in_b
);
   localparam int SETTLE = 1000;
   int   cnt_a = 0;
   int   cnt_b = 0;
   logic on_a  = 1'b0;
   logic on_b  = 1'b0;
   assign o_btn_a_no = i_press_a;
   assign o_btn_a_nc = !i_press_a;
   assign o_btn_b_no = i_press_b;
   assign o_btn_b_nc = !i_press_b;
   // Coil moves only after a settle time, so short off-test pulses do not drop it
   always @(posedge i_clock) begin
      cnt_a <= (i_safety_out_a == on_a) ? 0 : cnt_a + 1;
      cnt_b <= (i_safety_out_b == on_b) ? 0 : cnt_b + 1;
      if (cnt_a == SETTLE) on_a <= i_safety_out_a;
      if (cnt_b == SETTLE) on_b <= i_safety_out_b;
   end
   // Mirror contact: open while energised, or when the bench breaks the loop
   assign o_fb_in_a = !on_a && !i_open_a;
   assign o_fb_in_b = !on_b && !i_open_b;
endmodule // thc_far_side
`default_nettype wire

// >>> thc_checker_asserts.sv
// Concurrent checks on the two-hand control monitor ports
`timescale 1ns/1ps
`default_nettype none
module thc_checker
   import thc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_btn_a_no,
   input wire logic i_btn_b_no,
   input wire logic o_safety_out_a,
   input wire logic o_safety_out_b,
   input wire logic o_aux_out,
   input wire logic o_power_led,
   input wire logic o_chan_a_led,
   input wire logic o_chan_b_led,
   input wire logic o_ready,
   input wire logic o_error
);
   // Raw contact ages; glitches shorter than the filter are not modelled
   logic [31:0] both_q;
   logic [31:0] rel_q;
   logic        both;
   assign both = i_btn_a_no && i_btn_b_no;
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         both_q <= '0;
         rel_q  <= '0;
      end else begin
         both_q <= both ? both_q + 32'h0000_0001 : '0;
         rel_q  <= both ? '0 : rel_q + 32'h0000_0001;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   a_aux_tracks: assert property (o_safety_out_a || o_safety_out_b |-> o_aux_out)
      else $error("safety output on without aux");
   a_led_follow: assert property (!o_error |-> o_chan_a_led == o_aux_out && o_chan_b_led == o_aux_out)
      else $error("channel leds differ from outputs");
   a_power_first: assert property (!o_power_led |-> !o_aux_out && !o_ready)
      else $error("active before power led");
   a_err_blocks: assert property (o_error |-> !o_aux_out && !o_safety_out_a && !o_safety_out_b)
      else $error("outputs on in error");
   a_fb_checked: assert property ($rose(o_aux_out) |-> $past(o_ready, 2) && o_safety_out_a && o_safety_out_b)
      else $error("switch-on without ready");
   a_rise_pressed: assert property ($rose(o_aux_out) |-> both_q >= DEBOUNCE_CYCLES)
      else $error("switch-on without both buttons");
   a_release_low: assert property (rel_q > DEBOUNCE_CYCLES + 16 |-> !o_aux_out && !o_safety_out_a)
      else $error("outputs on after release");
   a_rearm_gap: assert property ($fell(o_aux_out) |-> !o_aux_out [*8])
      else $error("outputs back on at once");
   c_arm: cover property ($rose(o_aux_out));
   c_err: cover property ($rose(o_error));
   c_pwr: cover property ($rose(o_power_led));
endmodule // thc_checker
bind two_hand_control_logic thc_checker thc_checker_inst (.i_clock(i_clock),
   .i_resetn(i_resetn), .i_btn_a_no(i_btn_a_no), .i_btn_b_no(i_btn_b_no),
   .o_safety_out_a(o_safety_out_a), .o_safety_out_b(o_safety_out_b), .o_aux_out(o_aux_out),
   .o_power_led(o_power_led), .o_chan_a_led(o_chan_a_led), .o_chan_b_led(o_chan_b_led),
   .o_ready(o_ready), .o_error(o_error));
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the two-hand control monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import thc_pkg::*;
;
   // Each step waits out the input filter plus the contactor settle time
   localparam int WAIT = DEBOUNCE_CYCLES + 2000;
   logic i_clock      = 1'b0;
   logic i_resetn     = 1'b0;
   logic press_a      = 1'b0;
   logic press_b      = 1'b0;
   logic open_a       = 1'b0;
   logic safety_reset = 1'b0;
   logic or_link      = 1'b0;
   logic and_link     = 1'b0;
   logic and_mode     = 1'b0;
   logic btn_a_no, btn_a_nc, btn_b_no, btn_b_nc, fb_a, fb_b;
   logic out_a, out_b, aux, pwr, led_a, led_b, rdy, err;
   int   failures     = 0;
   int   compares     = 0;
   always #2 i_clock = ~i_clock;
   thc_far_side thc_far_side_inst (.i_clock(i_clock), .i_press_a(press_a),
      .i_press_b(press_b), .i_open_a(open_a), .i_open_b(1'b0), .i_safety_out_a(out_a),
      .i_safety_out_b(out_b), .o_btn_a_no(btn_a_no), .o_btn_a_nc(btn_a_nc),
      .o_btn_b_no(btn_b_no), .o_btn_b_nc(btn_b_nc), .o_fb_in_a(fb_a), .o_fb_in_b(fb_b));
   two_hand_control_logic two_hand_control_logic_inst (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_btn_a_no(btn_a_no), .i_btn_a_nc(btn_a_nc),
      .i_btn_b_no(btn_b_no), .i_btn_b_nc(btn_b_nc), .i_fb_in_a(fb_a), .i_fb_in_b(fb_b),
      .i_or_link_in(or_link), .i_and_link_in(and_link), .i_and_mode(and_mode),
      .i_safety_reset(safety_reset), .o_safety_out_a(out_a), .o_safety_out_b(out_b),
      .o_aux_out(aux), .o_power_led(pwr), .o_chan_a_led(led_a), .o_chan_b_led(led_b),
      .o_ready(rdy), .o_error(err));
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_outs(input logic v);
      chk(out_a, v);
      chk(out_b, v);
      chk(aux, v);
      chk(led_a, v);
      chk(led_b, v);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic buttons(input logic a, input logic b);
      @(negedge i_clock);
      press_a = a;
      press_b = b;
      idle(WAIT);
   endtask
   task automatic close_out();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (90_000) @(posedge i_clock);
      failures++;
      close_out();
   end
   initial begin
      idle(2);
      i_resetn = 1'b1;
      idle(INIT_CYCLES + 2 * DEBOUNCE_CYCLES - 8);
      chk(pwr, 1'b0);
      idle(16);
      chk(pwr, 1'b1);
      chk(rdy, 1'b1);
      $display("test init done");
      buttons(1'b1, 1'b0);
      chk_outs(1'b0);
      buttons(1'b0, 1'b0);
      buttons(1'b1, 1'b1);
      chk_outs(1'b1);
      buttons(1'b1, 1'b0);
      chk_outs(1'b0);
      buttons(1'b1, 1'b1);
      chk_outs(1'b0);
      buttons(1'b0, 1'b0);
      buttons(1'b1, 1'b1);
      chk_outs(1'b1);
      buttons(1'b0, 1'b0);
      // Contactors drop late, so let the feedback filter see the loop closed
      idle(WAIT);
      $display("test arm done");
      open_a = 1'b1;
      idle(WAIT);
      chk(rdy, 1'b0);
      buttons(1'b1, 1'b1);
      chk(out_a, 1'b0);
      chk(out_b, 1'b0);
      chk(aux, 1'b0);
      chk(err, 1'b1);
      chk(led_a ^ led_b, 1'b1);
      open_a = 1'b0;
      buttons(1'b0, 1'b0);
      buttons(1'b1, 1'b1);
      chk(aux, 1'b0);
      buttons(1'b0, 1'b0);
      safety_reset = 1'b1;
      idle(WAIT);
      chk(err, 1'b0);
      safety_reset = 1'b0;
      buttons(1'b1, 1'b1);
      chk_outs(1'b1);
      buttons(1'b0, 1'b0);
      $display("test feedback done");
      // Mode strap is caught only at init, so AND mode needs a fresh reset
      and_mode = 1'b1;
      i_resetn = 1'b0;
      idle(2);
      chk(pwr, 1'b0);
      i_resetn = 1'b1;
      idle(INIT_CYCLES + 2 * DEBOUNCE_CYCLES + 8);
      chk(pwr, 1'b1);
      buttons(1'b1, 1'b1);
      chk(aux, 1'b0);
      buttons(1'b0, 1'b0);
      and_link = 1'b1;
      buttons(1'b1, 1'b1);
      chk_outs(1'b1);
      buttons(1'b0, 1'b0);
      and_link = 1'b0;
      or_link  = 1'b1;
      buttons(1'b1, 1'b1);
      chk_outs(1'b1);
      buttons(1'b0, 1'b0);
      $display("test link done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
